// ---- drf_fifo.sv ----
// input sample buffer with registered ready
module drf_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int PW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
			$error("drf_fifo depth must be a power of two >= 2");
		end
	endgenerate
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [PW-1:0] wp, rp, next_wp, next_rp; // pointers
	logic [PW:0] cnt, next_cnt; // fill level
	logic rdy, next_rdy; // registered not-full
	logic push, pop;
	// next pointer and level
	always_comb begin
		push = in_valid_i && rdy;
		pop = out_ready_i && (cnt != '0);
		next_wp = push ? wp + 1'b1 : wp;
		next_rp = pop ? rp + 1'b1 : rp;
		next_cnt = cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		next_rdy = (next_cnt != (PW + 1)'(DEPTH));
	end
	// register state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			rdy <= 1'b0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
			rdy <= next_rdy;
		end
	end
	// storage write
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp] <= in_data_i;
		end
	end
	assign in_ready_o = rdy;
	assign out_valid_o = (cnt != '0);
	assign out_data_o = mem[rp];
	assign level_o = cnt;
endmodule

// ---- drf_filter.sv ----
// decimating coefficient-memory fir, one channel, wishbone registers
module drf_filter #(
	parameter int COEF_W = drf_pkg::COEF_W_DEC, // channel variant uses 20
	parameter int FIFO_DEPTH = drf_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// samples from helper filter
	input wire logic in_valid_i,
	input wire drf_pkg::drf_sample_t in_sample_i,
	output logic in_ready_o,
	// samples to next stage
	output logic out_valid_o,
	output drf_pkg::drf_sample_t out_sample_o
);
	localparam int DW = drf_pkg::DATA_W;
	localparam int AW = drf_pkg::RAM_AW;
	localparam int TW = drf_pkg::TAP_W;
	localparam int PW = DW + COEF_W; // product width
	localparam int ACC_W = PW + TW; // accumulator width
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	generate
		if (COEF_W < 2 || COEF_W > 24 || LW > 5) begin : g_chk
			$error("drf_filter: unsupported coefficient width or depth");
		end
	endgenerate

	// byte-lane merge for bus writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// drop fraction bits, attenuate by scale word, saturate
	function automatic logic signed [DW-1:0] scale_sat(input logic signed [ACC_W-1:0] a, input logic [1:0] sc);
		logic signed [ACC_W-1:0] s;
		logic signed [ACC_W-1:0] hi;
		logic signed [ACC_W-1:0] lo;
		s = a >>> (COEF_W - 1); // coefficients are q1.(w-1)
		s = s >>> (2'd3 - sc); // 00 -> /8, 01 -> /4, 10 -> /2, 11 -> 1
		hi = ACC_W'((1 << (DW - 1)) - 1);
		lo = -hi - 1;
		if (s > hi) begin
			return hi[DW-1:0];
		end else if (s < lo) begin
			return lo[DW-1:0];
		end else begin
			return s[DW-1:0];
		end
	endfunction

	// coefficient address of tap k
	function automatic logic [AW-1:0] coef_addr(input logic [TW-1:0] k, input logic [TW-1:0] n_m1,
		input logic [AW-1:0] off, input logic sym);
		logic [TW-1:0] c;
		logic [TW-1:0] m;
		c = TW'(({1'b0, n_m1} + 1'b1) >> 1); // floor(taps/2), no wrap at 128 taps
		if (sym) begin
			// second half stored from middle on; first half mirrors it
			m = (k >= c) ? k - c : n_m1 - k - c;
		end else begin
			// stored last coefficient first
			m = n_m1 - k;
		end
		return off + m[AW-1:0];
	endfunction

	// ---------------- register file ----------------
	drf_pkg::drf_ctrl_t ctrl, next_ctrl; // control word
	logic [TW-1:0] taps, next_taps; // taps minus one
	logic [AW-1:0] offset, next_offset; // coefficient set base
	logic [AW-1:0] start_a, next_start_a; // memory window start
	logic [AW-1:0] stop_a, next_stop_a; // memory window stop
	logic [AW-1:0] ptr, next_ptr; // coefficient access pointer
	logic ack, next_ack; // bus acknowledge
	logic [31:0] rdat, next_rdat; // bus read data
	logic [COEF_W-1:0] cram [drf_pkg::RAM_DEPTH]; // coefficient memory
	logic cram_we; // bus write into memory
	logic req; // new bus cycle
	logic [31:0] wv; // merged write value
	logic [LW-1:0] level; // buffer fill
	drf_pkg::drf_state_t st, next_st; // engine state

	// bus decode and register next values
	always_comb begin
		next_ctrl = ctrl;
		next_taps = taps;
		next_offset = offset;
		next_start_a = start_a;
		next_stop_a = stop_a;
		next_ptr = ptr;
		next_rdat = 32'h0000_0000;
		cram_we = 1'b0;
		wv = 32'h0000_0000;
		req = wb_cyc_i && wb_stb_i && !ack;
		next_ack = req;
		if (req) begin
			case (wb_adr_i)
				drf_pkg::REG_CTRL: begin
					wv = merge({20'h00000, ctrl}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						next_ctrl = wv[11:0];
					end
					next_rdat = {20'h00000, ctrl};
				end
				drf_pkg::REG_TAPS: begin
					wv = merge({25'h0000000, taps}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						next_taps = wv[TW-1:0];
					end
					next_rdat = {25'h0000000, taps};
				end
				drf_pkg::REG_OFFSET: begin
					wv = merge({26'h0000000, offset}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						next_offset = wv[AW-1:0];
					end
					next_rdat = {26'h0000000, offset};
				end
				drf_pkg::REG_START: begin
					wv = merge({26'h0000000, start_a}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						next_start_a = wv[AW-1:0];
						next_ptr = wv[AW-1:0]; // rearm window
					end
					next_rdat = {26'h0000000, start_a};
				end
				drf_pkg::REG_STOP: begin
					wv = merge({26'h0000000, stop_a}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						next_stop_a = wv[AW-1:0];
						next_ptr = start_a; // rearm window
					end
					next_rdat = {26'h0000000, stop_a};
				end
				drf_pkg::REG_COEF: begin
					cram_we = wb_we_i && (wb_sel_i != 4'h0);
					next_rdat = 32'(cram[ptr]);
					// every access steps, holds at stop
					next_ptr = (ptr == stop_a) ? ptr : ptr + 1'b1;
				end
				drf_pkg::REG_STATUS: begin
					next_rdat = 32'h0000_0000;
					next_rdat[drf_pkg::STAT_ADDR +: AW] = ptr;
					next_rdat[drf_pkg::STAT_BUSY] = (st != drf_pkg::ST_IDLE);
					next_rdat[drf_pkg::STAT_LEVEL +: LW] = level;
				end
				default: begin
					next_rdat = 32'h0000_0000; // unmapped reads zero
				end
			endcase
		end
	end

	// register file flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= drf_pkg::CTRL_RST;
			taps <= drf_pkg::TAPS_RST;
			offset <= '0;
			start_a <= '0;
			stop_a <= '0;
			ptr <= '0;
			ack <= 1'b0;
			rdat <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			taps <= next_taps;
			offset <= next_offset;
			start_a <= next_start_a;
			stop_a <= next_stop_a;
			ptr <= next_ptr;
			ack <= next_ack;
			rdat <= next_rdat;
		end
	end

	// coefficient memory write, low bits of the word
	always_ff @(posedge clk_i) begin
		if (cram_we) begin
			cram[ptr] <= wb_dat_i[COEF_W-1:0];
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;

	// ---------------- input buffer ----------------
	logic fifo_valid; // sample waiting
	logic fifo_pop; // engine takes sample
	drf_pkg::drf_sample_t fifo_s; // head sample

	drf_fifo #(
		.WIDTH(2 * DW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(in_valid_i),
		.in_data_i(in_sample_i),
		.in_ready_o(in_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_s),
		.out_ready_i(fifo_pop),
		.level_o(level)
	);

	// ---------------- filter engine ----------------
	logic signed [DW-1:0] hist_i [drf_pkg::HIST_DEPTH]; // i history
	logic signed [DW-1:0] hist_q [drf_pkg::HIST_DEPTH]; // q history
	logic [TW-1:0] wp, next_wp; // newest slot plus one
	logic [3:0] dcnt, next_dcnt; // decimation phase counter
	logic [TW-1:0] k, next_k; // current tap
	logic [TW-1:0] taps_l, next_taps_l; // latched tap count
	logic [AW-1:0] off_l, next_off_l; // latched offset
	logic sym_l, next_sym_l; // latched symmetry
	logic [1:0] sc_l, next_sc_l; // latched scale
	logic signed [ACC_W-1:0] acc_i, next_acc_i; // i sum
	logic signed [ACC_W-1:0] acc_q, next_acc_q; // q sum
	logic ov, next_ov; // output strobe
	drf_pkg::drf_sample_t os, next_os; // output sample
	logic [TW-1:0] hidx; // history slot of tap k
	logic signed [COEF_W-1:0] cf; // coefficient of tap k
	logic signed [PW-1:0] p_i, p_q; // tap products

	// one tap per clock on each of two multipliers
	always_comb begin
		hidx = wp - 1'b1 - k;
		cf = cram[coef_addr(k, taps_l, off_l, sym_l)];
		p_i = hist_i[hidx] * cf;
		p_q = hist_q[hidx] * cf;
	end

	// engine next values
	always_comb begin
		next_st = st;
		next_wp = wp;
		next_dcnt = dcnt;
		next_k = k;
		next_taps_l = taps_l;
		next_off_l = off_l;
		next_sym_l = sym_l;
		next_sc_l = sc_l;
		next_acc_i = acc_i;
		next_acc_q = acc_q;
		next_ov = 1'b0;
		next_os = os;
		fifo_pop = 1'b0;
		case (st)
			drf_pkg::ST_IDLE: begin
				if (fifo_valid) begin
					fifo_pop = 1'b1; // stalls while running, buffer absorbs
					next_wp = wp + 1'b1;
					if (ctrl.bypass) begin
						next_ov = 1'b1;
						next_os = fifo_s;
					end else begin
						// factor minus one wraps the counter
						next_dcnt = (dcnt >= ctrl.decim_m1) ? 4'h0 : dcnt + 4'h1;
						if (dcnt == ctrl.phase) begin
							next_st = drf_pkg::ST_RUN;
							next_k = '0;
							next_taps_l = taps; // settings frozen per output
							next_off_l = offset;
							next_sym_l = ctrl.sym;
							next_sc_l = ctrl.scale;
							next_acc_i = '0;
							next_acc_q = '0;
						end
					end
				end
			end
			drf_pkg::ST_RUN: begin
				next_acc_i = acc_i + ACC_W'(p_i);
				next_acc_q = acc_q + ACC_W'(p_q);
				next_k = k + 1'b1;
				if (k == taps_l) begin // taps minus one reached
					next_st = drf_pkg::ST_DONE;
				end
			end
			drf_pkg::ST_DONE: begin
				next_ov = 1'b1;
				next_os.i = scale_sat(acc_i, sc_l);
				next_os.q = scale_sat(acc_q, sc_l);
				next_st = drf_pkg::ST_IDLE;
			end
			default: begin
				next_st = drf_pkg::ST_IDLE;
			end
		endcase
	end

	// engine flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= drf_pkg::ST_IDLE;
			wp <= '0;
			dcnt <= 4'h0;
			k <= '0;
			taps_l <= '0;
			off_l <= '0;
			sym_l <= 1'b0;
			sc_l <= 2'h3;
			acc_i <= '0;
			acc_q <= '0;
			ov <= 1'b0;
			os <= '0;
		end else begin
			st <= next_st;
			wp <= next_wp;
			dcnt <= next_dcnt;
			k <= next_k;
			taps_l <= next_taps_l;
			off_l <= next_off_l;
			sym_l <= next_sym_l;
			sc_l <= next_sc_l;
			acc_i <= next_acc_i;
			acc_q <= next_acc_q;
			ov <= next_ov;
			os <= next_os;
		end
	end

	// sample history write
	always_ff @(posedge clk_i) begin
		if (fifo_pop) begin
			hist_i[wp] <= fifo_s.i;
			hist_q[wp] <= fifo_s.q;
		end
	end

	assign out_valid_o = ov;
	assign out_sample_o = os;
endmodule

// ---- drf_filter_chk.sv ----
// watches bus answers, pointer and output strobes
module drf_filter_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic out_valid_o,
	input wire drf_pkg::drf_sample_t out_sample_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tk; // request taken
	logic wr; // full word write taken
	logic [11:0] ctl, next_ctl; // control copy
	logic [5:0] st, sp, pt, next_st, next_sp, next_pt; // pointer model
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = tk && wb_we_i && wb_sel_i == 4'hF;
	// next copies
	always_comb begin
		next_ctl = ctl;
		next_st = st;
		next_sp = sp;
		next_pt = pt;
		// control copy follows byte lanes like the register
		if (tk && wb_we_i && wb_adr_i == drf_pkg::REG_CTRL) begin
			if (wb_sel_i[0]) next_ctl[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1]) next_ctl[11:8] = wb_dat_i[11:8];
		end
		if (wr && wb_adr_i == drf_pkg::REG_START) begin
			next_st = wb_dat_i[5:0];
			next_pt = wb_dat_i[5:0];
		end
		if (wr && wb_adr_i == drf_pkg::REG_STOP) begin
			next_sp = wb_dat_i[5:0];
			next_pt = st;
		end
		if (tk && wb_adr_i == drf_pkg::REG_COEF && pt != sp) next_pt = pt + 6'h01;
	end
	// copies registered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl <= drf_pkg::CTRL_RST;
			st <= 6'h00;
			sp <= 6'h00;
			pt <= 6'h00;
		end else begin
			ctl <= next_ctl;
			st <= next_st;
			sp <= next_sp;
			pt <= next_pt;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// read request at one address
	sequence s_rd(logic [7:0] a);
		tk && !wb_we_i && wb_adr_i == a;
	endsequence
	a_ack_next: assert property (tk |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(tk)) else $error("stray ack");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
	a_ctrl_back: assert property (s_rd(drf_pkg::REG_CTRL) |=> wb_dat_o[11:0] == ctl) else $error("ctrl");
	a_ptr_status: assert property (s_rd(drf_pkg::REG_STATUS) |=> wb_dat_o[5:0] == pt) else $error("ptr");
	a_unmapped_zero: assert property (s_rd(8'h1C) |=> wb_dat_o == 32'h0) else $error("unmapped");
	a_sample_hold: assert property (!out_valid_o |-> $stable(out_sample_o)) else $error("hold");
	a_tap_spacing: assert property (out_valid_o && !ctl[0] && !$past(ctl[0]) |=> !out_valid_o [*2])
		else $error("spacing");
endmodule
bind drf_filter drf_filter_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .out_valid_o(out_valid_o), .out_sample_o(out_sample_o));

// ---- drf_filter_tb.sv ----
module drf_filter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic stall = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF; // byte lanes
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, bus_rd;
	logic ack, pv, rdy, ov;
	drf_pkg::drf_sample_t ps, os;
	logic [3:0] mm[3] = '{4'h3, 4'h3, 4'hF}; // factor minus one
	logic [3:0] ph[3] = '{4'h0, 4'h3, 4'hF}; // phase
	int num_errors = 0;
	int tests_run = 0;
	drf_filter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .in_valid_i(pv), .in_sample_i(ps),
		.in_ready_o(rdy), .out_valid_o(ov), .out_sample_o(os));
	drf_partner pm (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_i(rdy), .out_valid_i(ov),
		.out_sample_i(os), .valid_o(pv), .sample_o(ps));
	initial forever #25 clk_i = ~clk_i;
	task automatic conclude;
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one classic cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		bus_rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(n, {8'h00, e}, {8'h00, bus_rd});
	endtask
	task automatic cfg(input logic [31:0] t, input logic [31:0] o, input logic [31:0] a, input logic [31:0] b);
		wr(drf_pkg::REG_TAPS, t);
		wr(drf_pkg::REG_OFFSET, o);
		wr(drf_pkg::REG_START, a);
		wr(drf_pkg::REG_STOP, b);
	endtask
	// i carries v, q carries minus v
	function automatic drf_pkg::drf_sample_t smp(input logic [19:0] v);
		return {v, 20'h00000 - v};
	endfunction
	task automatic send(input logic [19:0] v, input int n);
		repeat (n) pm.tx.push_back(smp(v));
	endtask
	// wait for n outputs, settle, then compare count and one
	task automatic outs(input int n, input int i, input logic [19:0] v);
		int k;
		k = 0;
		while (pm.got.size() < n && k < 3000) begin
			@(posedge clk_i);
			k++;
		end
		repeat (40) @(posedge clk_i);
		chk("count", 40'(n), 40'(pm.got.size()));
		chk("sample", smp(v), pm.got[i]);
		pm.got.delete();
	endtask
	initial begin
		repeat (10000) @(posedge clk_i);
		num_errors++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("ctrl", drf_pkg::REG_CTRL, 32'h0000000C);
		rd("taps", drf_pkg::REG_TAPS, 32'h0);
		rd("unmapped", 8'h1C, 32'h0);
		bus(1'b1, drf_pkg::REG_CTRL, 32'h00000A3C, 4'h1);
		rd("ctrl low", drf_pkg::REG_CTRL, 32'h0000003C);
		bus(1'b1, drf_pkg::REG_CTRL, 32'h00000A3C, 4'h2);
		rd("ctrl high", drf_pkg::REG_CTRL, 32'h00000A3C);
		cfg(32'h0, 32'h0, 32'h3, 32'h5);
		for (int k = 0; k < 4; k++) begin
			rd("pointer", drf_pkg::REG_STATUS, (k < 2) ? 32'(3 + k) : 32'h5);
			wr(drf_pkg::REG_COEF, 32'h0);
		end
		cfg(32'h0, 32'h0, 32'h9, 32'h9);
		wr(drf_pkg::REG_COEF, 32'h1234);
		wr(drf_pkg::REG_START, 32'h9);
		rd("coef", drf_pkg::REG_COEF, 32'h1234);
		cfg(32'h0, 32'h0, 32'h0, 32'h0);
		wr(drf_pkg::REG_COEF, 32'h0800);
		for (int s = 0; s < 4; s++) begin
			wr(drf_pkg::REG_CTRL, 32'(s << 2));
			send(20'h10000, 1);
			outs(1, 0, 20'(20'h04000 >> (3 - s)));
		end
		// bypass with a stalled source
		wr(drf_pkg::REG_CTRL, 32'h1);
		stall <= 1'b1;
		for (int k = 0; k < 3; k++) send(20'h0ABC0 + 20'(k), 1);
		repeat (5) @(posedge clk_i);
		stall <= 1'b0;
		outs(3, 2, 20'h0ABC2);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int t = 0; t < 3; t++) begin
			wr(drf_pkg::REG_CTRL, {20'h0, ph[t], mm[t], 4'hC});
			for (int k = 0; k < 2 * (mm[t] + 1); k++) send(20'(k + 1) << 11, 1);
			outs(2, 1, 20'(ph[t] + mm[t] + 2) << 9);
		end
		// two sets, last coefficient first
		wr(drf_pkg::REG_CTRL, 32'h0000000C);
		cfg(32'h1, 32'h0, 32'h0, 32'h1);
		wr(drf_pkg::REG_COEF, 32'h0400);
		wr(drf_pkg::REG_COEF, 32'h0800);
		cfg(32'h1, 32'h0, 32'h2, 32'h3);
		wr(drf_pkg::REG_COEF, 32'h1000);
		wr(drf_pkg::REG_COEF, 32'h1000);
		send(20'h08000, 3);
		outs(3, 2, 20'h03000);
		wr(drf_pkg::REG_OFFSET, 32'h2);
		send(20'h08000, 3);
		outs(3, 2, 20'h08000);
		// twenty taps fill the buffer
		cfg(32'h13, 32'h0, 32'h0, 32'h13);
		for (int k = 0; k < 20; k++) wr(drf_pkg::REG_COEF, 32'h0100);
		send(20'h08000, 24);
		repeat (12) @(posedge clk_i);
		rd("status", drf_pkg::REG_STATUS, 32'h8113);
		chk("ready", 40'h0, {39'h0, rdy});
		outs(24, 23, 20'h05000);
		rd("drained", drf_pkg::REG_STATUS, 32'h0013);
		wr(drf_pkg::REG_CTRL, 32'h0000000E);
		cfg(32'h3, 32'h3E, 32'h3E, 32'h1);
		wr(drf_pkg::REG_COEF, 32'h0800);
		wr(drf_pkg::REG_COEF, 32'h0400);
		send(20'h08000, 6);
		outs(6, 5, 20'h06000);
		conclude();
	end
endmodule

// ---- drf_partner.sv ----
// upstream sample source and downstream sink
module drf_partner (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic ready_i,
	input wire logic out_valid_i,
	input wire drf_pkg::drf_sample_t out_sample_i,
	output logic valid_o = 1'b0,
	output drf_pkg::drf_sample_t sample_o = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	drf_pkg::drf_sample_t tx[$]; // queued to send
	drf_pkg::drf_sample_t got[$]; // collected outputs
	// hold until taken, idle data toggles
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
		end else begin
			if (out_valid_i === 1'b1) got.push_back(out_sample_i);
			if (valid_o && ready_i === 1'b1) void'(tx.pop_front());
			if (!valid_o || ready_i === 1'b1) begin
				valid_o <= tx.size() > 0 && !stall_i;
				sample_o <= (tx.size() > 0 && !stall_i) ? tx[0] : ~sample_o;
			end
		end
	end
endmodule

// ---- drf_pkg.sv ----
// Contract
// - 64 asymmetric or 128 symmetric taps, 64-entry memory
// - decimation 1 to 16, stored minus one
// - 20-bit samples in and out, 14-bit coefficients
// - tap count holds taps minus one
// - bypass passes input unchanged, no scaling
// - scale word 00/01/10/11 gives 18/12/6/0 dB
// - symmetric mode stores only half the response
// - offset change applies from next output sample
// - 4-bit phase word picks the decimation phase
// - two multipliers, one tap per clock each
// - output rate is input rate over decimation; in bypass every input sample is output, whatever the decimation field
// - coefficient access steps address from start to stop
// - channel variant differs only by 20-bit coefficients
package drf_pkg;
	localparam int DATA_W = 20; // sample width
	localparam int COEF_W_DEC = 14; // decimating stage coefficients
	localparam int COEF_W_CHAN = 20; // channel stage coefficients
	localparam int RAM_DEPTH = 64; // coefficient entries
	localparam int RAM_AW = 6; // coefficient address width
	localparam int TAP_W = 7; // tap count field width
	localparam int HIST_DEPTH = 128; // sample history length
	localparam int FIFO_DEPTH = 8; // input buffer words
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TAPS = 8'h04;
	localparam logic [7:0] REG_OFFSET = 8'h08;
	localparam logic [7:0] REG_START = 8'h0C;
	localparam logic [7:0] REG_STOP = 8'h10;
	localparam logic [7:0] REG_COEF = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	// control field positions
	localparam int CTRL_BYPASS = 0;
	localparam int CTRL_SYM = 1;
	localparam int CTRL_SCALE = 2; // two bits
	localparam int CTRL_DECIM = 4; // four bits, factor minus one
	localparam int CTRL_PHASE = 8; // four bits
	// status field positions
	localparam int STAT_ADDR = 0; // six bits, coefficient pointer
	localparam int STAT_BUSY = 8;
	localparam int STAT_LEVEL = 12; // four bits, buffer fill
	// reset values
	localparam logic [11:0] CTRL_RST = 12'h00C; // no scaling, m=1
	localparam logic [6:0] TAPS_RST = 7'h00;
	// one I/Q sample
	typedef struct packed {
		logic signed [DATA_W-1:0] i;
		logic signed [DATA_W-1:0] q;
	} drf_sample_t;
	// decoded control word
	typedef struct packed {
		logic [3:0] phase;
		logic [3:0] decim_m1;
		logic [1:0] scale;
		logic sym;
		logic bypass;
	} drf_ctrl_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} drf_state_t;
endpackage
